// ===== rsc_regs.sv
// status, reserved, action trigger, mask registers plus the paired flags
// assumes a register port from the serial engine on clk_i, one access a
// cycle; status pins come from analog blocks and are synchronised here
// What this block does
// RULE_01: status read-only; bits 7,6 report sync-rate fault
// RULE_02: status bit 5 shows aux converter full duty
// RULE_03: status bit 4 shows constant-current regulation
// RULE_04: status bit 3 shows main converter full duty
// RULE_05: status bit 2 power good; bits 1,0 zero
// RULE_06: reserved address has no function, reads zero
// RULE_07: action register write triggers selected action
// RULE_08: bit 1 applies setpoint, always reads zero
// RULE_09: writing bit 0 starts main converter
// RULE_10: two read/write masks gate matching flag bits
// RULE_11: mask-all forces every mask bit to one
// RULE_12: first mask uses bits 7,5,4,3,2,0
// RULE_13: second mask uses bits 6 down to 0
// RULE_14: flags clear on read once cause gone
// RULE_15: mask-all resets to one
// RULE_16: interrupt raised for any unmasked set flag
`timescale 1ns/1ps
module rsc_regs
  import rsc_regs_pkg::*;
(
  input  wire logic      clk_i,                     // 200 MHz core clock
  input  wire logic      nrst_i,                    // async reset, low
  input  wire rsc_byte_t reg_addr_i,                // register offset
  input  wire logic      reg_wr_i,                  // write strobe
  input  wire rsc_byte_t reg_wdata_i,               // write data
  input  wire logic      reg_rd_i,                  // read strobe
  output rsc_byte_t      reg_rdata_o,               // read data, next cycle
  input  wire logic      sync_rate_too_fast_i,      // pin, async
  input  wire logic      sync_rate_too_slow_i,      // pin, async
  input  wire logic      aux_full_duty_i,           // pin, async
  input  wire logic      constant_current_active_i, // pin, async
  input  wire logic      main_full_duty_i,          // pin, async
  input  wire logic      main_output_good_i,        // pin, async
  input  wire rsc_byte_t event_first_i,             // flag causes, level
  input  wire rsc_byte_t event_second_i,            // flag causes, level
  output logic           apply_setpoint_strobe_o,   // one-cycle pulse
  output logic           main_enable_strobe_o,      // one-cycle pulse
  output logic           irq_o                      // interrupt, level
);

  // two-stage synchroniser for the status pins
  rsc_status_t st_meta_reg;                  // first stage, read by 2nd only
  rsc_status_t st_sync_reg;                  // second stage, safe to use
  rsc_status_t st_pins;                      // raw pin bundle

  // register state
  rsc_byte_t   mask_first_reg;               // first mask
  rsc_byte_t   mask_first_next;
  rsc_byte_t   mask_second_reg;              // second mask
  rsc_byte_t   mask_second_next;
  logic        mask_all_reg;                 // global mask-all
  logic        mask_all_next;
  rsc_byte_t   flag_first_reg;               // first event flags
  rsc_byte_t   flag_first_next;
  rsc_byte_t   flag_second_reg;              // second event flags
  rsc_byte_t   flag_second_next;
  rsc_byte_t   rdata_next;
  logic        apply_next;
  logic        enable_next;
  logic        irq_next;
  rsc_byte_t   eff_first;                    // effective masks
  rsc_byte_t   eff_second;
  logic        wr_action;                    // decoded write and read helpers
  logic        rd_first;
  logic        rd_second;

  assign st_pins = {sync_rate_too_fast_i, sync_rate_too_slow_i,
                    aux_full_duty_i, constant_current_active_i,
                    main_full_duty_i, main_output_good_i};

  // synchroniser flops, nothing else looks at the first stage
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_meta_reg <= '0;
      st_sync_reg <= '0;
    end
    else
    begin
      st_meta_reg <= st_pins;
      st_sync_reg <= st_meta_reg;
    end
  end

  // next-state logic for masks, flags, strobes, read data, interrupt
  always_comb
  begin
    mask_first_next  = mask_first_reg;
    mask_second_next = mask_second_reg;
    mask_all_next    = mask_all_reg;
    apply_next       = 1'b0;
    enable_next      = 1'b0;
    rdata_next       = `RSC_RST_BYTE;
    wr_action        = reg_wr_i && (reg_addr_i == `RSC_OFS_ACTION);
    rd_first         = reg_rd_i && (reg_addr_i == `RSC_OFS_FLAG_FIRST);
    rd_second        = reg_rd_i && (reg_addr_i == `RSC_OFS_FLAG_SECOND);

    // writes; status and reserved ignore them
    if (reg_wr_i && reg_addr_i == `RSC_OFS_MASK_FIRST)
    begin
      mask_first_next = reg_wdata_i & `RSC_USED_FIRST;   // [RULE_10] [RULE_12]
    end
    else if (reg_wr_i && reg_addr_i == `RSC_OFS_MASK_SECOND)
    begin
      mask_second_next = reg_wdata_i & `RSC_USED_SECOND; // [RULE_10] [RULE_13]
    end
    else if (reg_wr_i && reg_addr_i == `RSC_OFS_CONFIG_ONE)
    begin
      mask_all_next = reg_wdata_i[`RSC_CFG_MASK_ALL];    // [RULE_15]
    end
    else if (wr_action)
    begin
      // a write is the trigger; bits above 1 do nothing
      apply_next  = reg_wdata_i[`RSC_ACT_APPLY];         // [RULE_07] [RULE_08]
      enable_next = reg_wdata_i[`RSC_ACT_ENABLE];        // [RULE_09]
    end

    // flags: a live cause always wins over the read clear
    flag_first_next  = (flag_first_reg &
                        ~(rd_first ? ~event_first_i : 8'h00)) |
                       event_first_i;                    // [RULE_14]
    flag_second_next = (flag_second_reg &
                        ~(rd_second ? ~event_second_i : 8'h00)) |
                       event_second_i;                   // [RULE_14]
    flag_first_next  = flag_first_next & `RSC_USED_FIRST;
    flag_second_next = flag_second_next & `RSC_USED_SECOND;

    // reads
    if (rd_first)
    begin
      rdata_next = flag_first_reg;
    end
    else if (rd_second)
    begin
      rdata_next = flag_second_reg;
    end
    else if (reg_rd_i && reg_addr_i == `RSC_OFS_STATUS)
    begin
      // fault, duty, mode, good bits [RULE_01] [RULE_02] [RULE_03] [RULE_04]
      rdata_next = {st_sync_reg, 2'b00};   // [RULE_05]
    end
    else if (reg_rd_i && reg_addr_i == `RSC_OFS_MASK_FIRST)
    begin
      rdata_next = mask_first_reg;
    end
    else if (reg_rd_i && reg_addr_i == `RSC_OFS_MASK_SECOND)
    begin
      rdata_next = mask_second_reg;
    end
    else if (reg_rd_i && reg_addr_i == `RSC_OFS_CONFIG_ONE)
    begin
      rdata_next = 8'h00;
      rdata_next[`RSC_CFG_MASK_ALL] = mask_all_reg;
    end
    else if (reg_rd_i)
    begin
      // reserved, action and unmapped all read zero
      rdata_next = `RSC_RST_BYTE;          // [RULE_06] [RULE_08]
    end
    else
    begin
      rdata_next = reg_rdata_o;            // hold last answer
    end

    // effective masks; mask-all overrides the stored values
    eff_first  = mask_all_reg ? 8'hFF : mask_first_reg;   // [RULE_11]
    eff_second = mask_all_reg ? 8'hFF : mask_second_reg;  // [RULE_11]
    irq_next   = |(flag_first_reg & ~eff_first) |
                 |(flag_second_reg & ~eff_second);        // [RULE_16]
  end

  // state registers only
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mask_first_reg          <= `RSC_RST_MASK;
      mask_second_reg         <= `RSC_RST_MASK;
      mask_all_reg            <= `RSC_RST_MASK_ALL;   // [RULE_15]
      flag_first_reg          <= `RSC_RST_FLAG;
      flag_second_reg         <= `RSC_RST_FLAG;
      reg_rdata_o             <= `RSC_RST_BYTE;
      apply_setpoint_strobe_o <= 1'b0;
      main_enable_strobe_o    <= 1'b0;
      irq_o                   <= 1'b0;
    end
    else
    begin
      mask_first_reg          <= mask_first_next;
      mask_second_reg         <= mask_second_next;
      mask_all_reg            <= mask_all_next;
      flag_first_reg          <= flag_first_next;
      flag_second_reg         <= flag_second_next;
      reg_rdata_o             <= rdata_next;
      apply_setpoint_strobe_o <= apply_next;
      main_enable_strobe_o    <= enable_next;
      irq_o                   <= irq_next;
    end
  end

  // checks on the outputs and stored state
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_status_read;
    reg_rd_i && reg_addr_i == `RSC_OFS_STATUS |=>
      reg_rdata_o == {$past(st_sync_reg), 2'b00};
  endproperty
  a_status_read: assert property (p_status_read) // [RULE_01]
    else $error("status read does not match pins");

  property p_status_low_zero;
    reg_rd_i && reg_addr_i == `RSC_OFS_STATUS |=> reg_rdata_o[1:0] == 2'b00;
  endproperty
  a_status_low_zero: assert property (p_status_low_zero) // [RULE_05]
    else $error("unused status bits not zero");

  property p_reserved_zero;
    reg_rd_i && reg_addr_i == `RSC_OFS_RESERVED |=> reg_rdata_o == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [RULE_06]
    else $error("reserved address read nonzero");

  property p_apply_pulse;
    reg_wr_i && reg_addr_i == `RSC_OFS_ACTION && reg_wdata_i[1] |=>
      apply_setpoint_strobe_o ##1
      (!apply_setpoint_strobe_o || $past(wr_action && reg_wdata_i[1]));
  endproperty
  a_apply_pulse: assert property (p_apply_pulse) // [RULE_08]
    else $error("setpoint apply pulse missing");

  property p_apply_cause;
    apply_setpoint_strobe_o |->
      $past(reg_wr_i) && $past(reg_addr_i) == `RSC_OFS_ACTION;
  endproperty
  a_apply_cause: assert property (p_apply_cause) // [RULE_07]
    else $error("setpoint apply without write");

  property p_enable_pulse;
    reg_wr_i && reg_addr_i == `RSC_OFS_ACTION |=>
      main_enable_strobe_o == $past(reg_wdata_i[0]);
  endproperty
  a_enable_pulse: assert property (p_enable_pulse) // [RULE_09]
    else $error("main enable pulse wrong");

  property p_action_reads_zero;
    reg_rd_i && reg_addr_i == `RSC_OFS_ACTION |=> reg_rdata_o[1] == 1'b0;
  endproperty
  a_action_reads_zero: assert property (p_action_reads_zero) // [RULE_08]
    else $error("apply bit read back as one");

  property p_mask_second_wr;
    reg_wr_i && reg_addr_i == `RSC_OFS_MASK_SECOND |=>
      mask_second_reg == ($past(reg_wdata_i) & 8'h7F);
  endproperty
  a_mask_second_wr: assert property (p_mask_second_wr) // [RULE_13]
    else $error("second mask write lost");

  property p_mask_first_unused;
    mask_first_reg[6] == 1'b0 && mask_first_reg[1] == 1'b0;
  endproperty
  a_mask_first_unused: assert property (p_mask_first_unused) // [RULE_12]
    else $error("unused first mask bit set");

  property p_mask_all_quiet;
    mask_all_reg ##1 mask_all_reg |-> !irq_o;
  endproperty
  a_mask_all_quiet: assert property (p_mask_all_quiet) // [RULE_11]
    else $error("interrupt despite mask-all");

  property p_irq_unmasked;
    !mask_all_reg && |(flag_second_reg & ~mask_second_reg) |=> irq_o;
  endproperty
  a_irq_unmasked: assert property (p_irq_unmasked) // [RULE_16]
    else $error("unmasked flag gave no interrupt");

  property p_read_clear;
    rd_first && event_first_i == 8'h00 |=> flag_first_reg == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear) // [RULE_14]
    else $error("flags not cleared by read");

  property p_cause_holds;
    rd_second |=>
      (flag_second_reg & $past(event_second_i) & `RSC_USED_SECOND) ==
      ($past(event_second_i) & `RSC_USED_SECOND);
  endproperty
  a_cause_holds: assert property (p_cause_holds) // [RULE_14]
    else $error("live cause cleared by read");

  c_apply: cover property (apply_setpoint_strobe_o);
  c_irq: cover property (!irq_o ##1 irq_o);
  c_clear: cover property (rd_first && |flag_first_reg);
  c_unmask: cover property ($fell(mask_all_reg));

endmodule : rsc_regs

// ===== rsc_regs_map.svh
// register map, field positions, reset values for the status/command/mask
// slice; included by rsc_regs_pkg and the bench
`ifndef RSC_REGS_MAP_SVH
`define RSC_REGS_MAP_SVH

// register offsets
`define RSC_OFS_FLAG_FIRST   8'h01
`define RSC_OFS_FLAG_SECOND  8'h02
`define RSC_OFS_STATUS       8'h03
`define RSC_OFS_RESERVED     8'h04
`define RSC_OFS_ACTION       8'h05
`define RSC_OFS_MASK_FIRST   8'h06
`define RSC_OFS_MASK_SECOND  8'h07
`define RSC_OFS_CONFIG_ONE   8'h08

// status field positions
`define RSC_ST_TOO_FAST      7
`define RSC_ST_TOO_SLOW      6
`define RSC_ST_AUX_FULL      5
`define RSC_ST_CC            4
`define RSC_ST_MAIN_FULL     3
`define RSC_ST_GOOD          2

// action_trigger field positions
`define RSC_ACT_APPLY        1
`define RSC_ACT_ENABLE       0

// config_byte_one mask-all position
`define RSC_CFG_MASK_ALL     5

// implemented bits of the mask / flag pairs
`define RSC_USED_FIRST       8'hBD
`define RSC_USED_SECOND      8'h7F

// reset values
`define RSC_RST_MASK         8'h00
`define RSC_RST_FLAG         8'h00
`define RSC_RST_MASK_ALL     1'b1
`define RSC_RST_BYTE         8'h00

`endif

// ===== rsc_regs_pkg.sv
// types shared by the status/command/mask register slice
// assumes rsc_regs_map.svh sits in the same folder
package rsc_regs_pkg;
  `include "rsc_regs_map.svh"

  // one register byte
  typedef logic [7:0] rsc_byte_t;

  // status pin group, top bit first
  typedef logic [5:0] rsc_status_t;
endpackage : rsc_regs_pkg

// ===== rsc_host_model.sv
// host-side register master for the status/command/mask slice
// assumes the bench calls its tasks, one access at a time on clk_i
`timescale 1ns/1ps
module rsc_host_model
  import rsc_regs_pkg::*;
(
  input  wire logic      clk_i,   // core clock
  input  wire rsc_byte_t rdata_i, // read data from the slice
  output rsc_byte_t      addr_o,  // register offset
  output rsc_byte_t      wdata_o, // write data
  output logic           wr_o,    // write strobe
  output logic           rd_o     // read strobe
);
  // quiet bus at time zero, nothing requested
  initial
  begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // one write, held across its sampling edge
  task automatic wr(input rsc_byte_t a, input rsc_byte_t d);
    @(posedge clk_i);
    #1;
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o    = 1'b0;
    // released lines are driven to the inverse, so a stale copy never helps
    addr_o  = ~a;
    wdata_o = ~d;
  endtask : wr

  // one read, data taken once the answer has landed
  task automatic rd(input rsc_byte_t a, output rsc_byte_t d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o   = 1'b1;
    @(posedge clk_i);
    #1;
    d      = rdata_i;
    rd_o   = 1'b0;
    addr_o = ~a;
  endtask : rd
endmodule : rsc_host_model

// ===== tb_top.sv
// self-checking bench for the status/command/mask slice
// assumes rsc_regs, rsc_host_model and rsc_regs_pkg are compiled first
`timescale 1ns/1ps
`include "rsc_regs_map.svh"
module tb_top
  import rsc_regs_pkg::*;
;
  logic        clk;         // 200 MHz
  logic        nrst;        // async reset, low
  logic  [5:0] stat;        // status pins, top bit first
  rsc_byte_t   ev1;         // first flag causes
  rsc_byte_t   ev2;         // second flag causes
  rsc_byte_t   addr;        // from host model
  rsc_byte_t   wdata;       // from host model
  logic        wr;          // from host model
  logic        rd;          // from host model
  rsc_byte_t   rdata;       // to host model
  logic        apply;       // setpoint strobe
  logic        enab;        // main enable strobe
  logic        irq;         // interrupt level
  int          bad_count;   // mismatches
  int          checks_done; // comparisons
  rsc_byte_t   d;           // last read value
  rsc_byte_t   act [4] = '{8'h02, 8'h01, 8'h03, 8'hFC}; // action codes

  rsc_regs DUT (
    .clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .sync_rate_too_fast_i(stat[5]), .sync_rate_too_slow_i(stat[4]),
    .aux_full_duty_i(stat[3]), .constant_current_active_i(stat[2]),
    .main_full_duty_i(stat[1]), .main_output_good_i(stat[0]),
    .event_first_i(ev1), .event_second_i(ev2),
    .apply_setpoint_strobe_o(apply), .main_enable_strobe_o(enab),
    .irq_o(irq));

  rsc_host_model host (
    .clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));

  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // compare and count; unknowns never match
  task automatic chk(input string n, input rsc_byte_t s, input rsc_byte_t e);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // read a register and compare
  task automatic rd_chk(input string n, input rsc_byte_t a,
                        input rsc_byte_t e);
    rsc_byte_t v;
    host.rd(a, v);
    chk(n, v, e);
  endtask : rd_chk

  // wait n edges, then the usual small drive delay
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // irq as a byte for the common compare
  task automatic irq_is(input logic e);
    chk("irq", {7'h00, irq}, {7'h00, e});
  endtask : irq_is

  // verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // hang guard, far beyond the roughly 130 cycles used
  initial
  begin
    #20000;
    bad_count++;
    close_out();
  end

  // main sequence
  initial
  begin
    bad_count = 0;
    checks_done = 0;
    nrst = 1'b0;
    stat = 6'h00;
    ev1 = 8'h00;
    ev2 = 8'h00;
    tick(20);
    nrst = 1'b1;
    irq_is(1'b0);
    rd_chk("mask1", `RSC_OFS_MASK_FIRST, 8'h00);
    rd_chk("mask2", `RSC_OFS_MASK_SECOND, 8'h00);
    rd_chk("cfg1", `RSC_OFS_CONFIG_ONE, 8'h20);
    // one status pin at a time; 3 edges covers sync plus read
    for (int i = 0; i < 6; i++)
    begin
      stat = 6'h01 << i;
      tick(3);
      host.rd(`RSC_OFS_STATUS, d);
      chk("st",d,{stat,2'b00});
    end
    // status ignores writes, reserved slot holds nothing
    host.wr(`RSC_OFS_STATUS, 8'h7F);
    rd_chk("st_ro", `RSC_OFS_STATUS, 8'h80);
    host.wr(`RSC_OFS_RESERVED, 8'hFF);
    rd_chk("rsvd", `RSC_OFS_RESERVED, 8'h00);
    // every action code: pulse now, gone next cycle
    foreach (act[k])
    begin
      host.wr(`RSC_OFS_ACTION, act[k]);
      chk("apply", {7'h00, apply}, {7'h00, act[k][1]});
      chk("enable", {7'h00, enab}, {7'h00, act[k][0]});
      tick(1);
      chk("pulse", {6'h00, apply, enab}, 8'h00);
    end
    rd_chk("act", `RSC_OFS_ACTION, 8'h00);
    // unused mask bits stay clear
    host.wr(`RSC_OFS_MASK_FIRST, 8'hFF);
    rd_chk("mask1", `RSC_OFS_MASK_FIRST, 8'hBD);
    host.wr(`RSC_OFS_MASK_SECOND, 8'hFF);
    rd_chk("mask2", `RSC_OFS_MASK_SECOND, 8'h7F);
    host.wr(`RSC_OFS_MASK_FIRST, 8'h00);
    host.wr(`RSC_OFS_MASK_SECOND, 8'h00);
    // one-cycle pulse on every first cause, mask-all still set
    ev1 = 8'hFF;
    tick(1);
    ev1 = 8'h00;
    tick(2);
    irq_is(1'b0);
    host.wr(`RSC_OFS_CONFIG_ONE, 8'h00);
    tick(1);
    irq_is(1'b1);
    host.wr(`RSC_OFS_MASK_FIRST, 8'hBD);
    tick(1);
    irq_is(1'b0);
    host.wr(`RSC_OFS_MASK_FIRST, 8'hBC);
    tick(1);
    irq_is(1'b1);
    host.wr(`RSC_OFS_CONFIG_ONE, 8'h20);
    tick(1);
    irq_is(1'b0);
    rd_chk("flag1", `RSC_OFS_FLAG_FIRST, 8'hBD);
    rd_chk("flag1", `RSC_OFS_FLAG_FIRST, 8'h00);
    // second flags with their cause held across reads
    host.wr(`RSC_OFS_MASK_FIRST, 8'h00);
    host.wr(`RSC_OFS_CONFIG_ONE, 8'h00);
    ev2 = 8'hFF;
    tick(1);
    rd_chk("flag2", `RSC_OFS_FLAG_SECOND, 8'h7F);
    rd_chk("flag2", `RSC_OFS_FLAG_SECOND, 8'h7F);
    host.wr(`RSC_OFS_MASK_SECOND, 8'h7F);
    tick(1);
    irq_is(1'b0);
    host.wr(`RSC_OFS_MASK_SECOND, 8'h3F);
    tick(1);
    irq_is(1'b1);
    ev2 = 8'h00;
    rd_chk("flag2", `RSC_OFS_FLAG_SECOND, 8'h7F);
    rd_chk("flag2", `RSC_OFS_FLAG_SECOND, 8'h00);
    tick(1);
    irq_is(1'b0);
    close_out();
  end
endmodule : tb_top
